/* File: adc_power_mode_control.v */
// Mode-control byte decode, power state and output code convention
// Functional notes
// - Mode byte with select 111 enters full power-down.
// - Full power-down turns off all analog, including reference; decode stays alive.
// - Only a valid mode byte with select 000, 001, 010, 100 or 110 leaves full power-down.
// - Chip-select activity without a complete valid byte never leaves power-down.
// - After power-up: full power, external clock mode.
// - After power-up every channel single-ended bipolar full reference.
// - Range code 011 selects unipolar zero to reference.
// - Negative unipolar: zero-scale gives 0x3fff, next down 0x3ffe.
// - Positive unipolar: zero-scale gives 0x0000, next up 0x0001.
// - Each channel range reprogrammable independently between conversions.
// - Mode byte starts at first one bit after chip select falls.
// - Bits 6..4 select mode; bits 3..0 must be 1000.
// - Select 100 restores all defaults.
// - Select 110 enters partial power-down, reference and bias stay on.
`timescale 1ns/1ns
`default_nettype none
`include "adc_mode_map.vh"
module adc_power_mode_control #(
   parameter CHANNELS = 8,
   parameter AW       = 3
) (
   input  wire          clock,          // 125 MHz system clock
   input  wire          reset_n,        // Synchronous reset, active low
   input  wire          sclk,           // Serial clock pin from host
   input  wire          cs_n,           // Chip select pin, active low
   input  wire          din,            // Serial data pin
   input  wire          range_wr,       // Range update from shift logic
   input  wire [AW-1:0] range_chan,     // Channel of range update
   input  wire [2:0]    range_code,     // New range code
   input  wire [AW-1:0] conv_chan,      // Channel being converted
   input  wire [13:0]   conv_raw,       // Raw offset-binary result
   output reg  [2:0]    mode_q,         // Active conversion mode
   output reg           analog_on_q,    // Analog sections powered
   output reg           ref_on_q,       // Reference and bias powered
   output reg           mode_byte_q,    // Pulse: valid mode byte taken
   output reg  [2:0]    chan_range_q,   // Range of conversion channel
   output reg  [13:0]   result_q        // Result code after convention
);
   // Pin synchronisers
   reg [1:0] sclk_s_q;
   reg [1:0] cs_s_q;
   reg [1:0] din_s_q;
   reg       sclk_prev_q;
   reg       armed_q;
   reg       in_byte_q;
   reg [2:0] cnt_q;
   reg [6:0] sh_q;
   reg [1:0] pwr_q;
   reg       defaults_q;
   wire [2:0] rd_range;
   wire       sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
   wire [7:0] byte_w    = {sh_q, din_s_q[1]};
   wire       last_bit  = sclk_rise & in_byte_q & (cnt_q == 3'h7) & ~cs_s_q[1];
   wire       byte_ok   = last_bit & (byte_w[3:0] == `CTRL_TAIL);
   wire [2:0] sel       = byte_w[`CTRL_MODE_HI:`CTRL_MODE_LO];

   // Two-flop synchronisers on every pin
   always @(posedge clock) begin
      if (!reset_n) begin
         sclk_s_q    <= 2'h0;
         cs_s_q      <= 2'h3;
         din_s_q     <= 2'h0;
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_s_q    <= {sclk_s_q[0], sclk};
         cs_s_q      <= {cs_s_q[0], cs_n};
         din_s_q     <= {din_s_q[0], din};
         sclk_prev_q <= sclk_s_q[1];
      end
   end

   // Byte framing: start bit is first one after chip select falls
   always @(posedge clock) begin
      if (!reset_n || cs_s_q[1]) begin
         armed_q   <= 1'b1;
         in_byte_q <= 1'b0;
         cnt_q     <= 3'h0;
         sh_q      <= 7'h00;
      end else if (sclk_rise) begin
         if (!in_byte_q && armed_q && din_s_q[1]) begin
            in_byte_q <= 1'b1;
            armed_q   <= 1'b0;
            cnt_q     <= 3'h1;
            sh_q      <= 7'h01;
         end else if (in_byte_q) begin
            sh_q  <= {sh_q[5:0], din_s_q[1]};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
               in_byte_q <= 1'b0;
               armed_q   <= 1'b1;
            end
         end
      end
   end

   // Mode and power state, changed only by a whole valid byte
   always @(posedge clock) begin
      if (!reset_n) begin
         mode_q      <= `MODE_EXT_CLOCK;
         pwr_q       <= `PWR_NORMAL;
         defaults_q  <= 1'b0;
         mode_byte_q <= 1'b0;
      end else begin
         defaults_q  <= 1'b0;
         mode_byte_q <= byte_ok;
         if (byte_ok) begin
            case (sel)
               `MODE_FULL_PD: begin
                  pwr_q <= `PWR_FULL;
               end
               `MODE_PARTIAL_PD: begin
                  pwr_q <= `PWR_PARTIAL;
               end
               `MODE_RESET: begin
                  mode_q     <= `MODE_EXT_CLOCK;
                  pwr_q      <= `PWR_NORMAL;
                  defaults_q <= 1'b1;
               end
               `MODE_EXT_CLOCK, `MODE_EXT_ACQ, `MODE_INT_CLOCK: begin
                  mode_q <= sel;
                  pwr_q  <= `PWR_NORMAL;
               end
               default: begin
                  mode_q <= mode_q;
               end
            endcase
         end
      end
   end

   // Power enables from state
   always @(posedge clock) begin
      if (!reset_n) begin
         analog_on_q <= 1'b1;
         ref_on_q    <= 1'b1;
      end else begin
         analog_on_q <= (pwr_q == `PWR_NORMAL);
         ref_on_q    <= (pwr_q != `PWR_FULL);
      end
   end

   // Per-channel ranges, defaults on reset and reset byte
   range_table #(.CHANNELS(CHANNELS), .AW(AW)) u_ranges (
      .clock   (clock),
      .reset_n (reset_n),
      .defaults(defaults_q),
      .wr_en   (range_wr),
      .wr_addr (range_chan),
      .wr_data (range_code),
      .rd_addr (conv_chan),
      .rd_data (rd_range)
   );

   // Output code convention per range
   always @(posedge clock) begin
      if (!reset_n) begin
         chan_range_q <= `RANGE_BIPOLAR_FULL;
         result_q     <= `CODE_ZERO_POS;
      end else begin
         chan_range_q <= rd_range;
         if (rd_range == 3'h2 || rd_range == 3'h4)
            result_q <= `CODE_ZERO_NEG - conv_raw;
         else
            result_q <= conv_raw;
      end
   end
endmodule // adc_power_mode_control
`default_nettype wire

/* File: adc_mode_map.vh */
// Constants for the converter mode and power control block
`ifndef ADC_MODE_MAP_VH
`define ADC_MODE_MAP_VH
`define MODE_EXT_CLOCK    3'h0
`define MODE_EXT_ACQ      3'h1
`define MODE_INT_CLOCK    3'h2
`define MODE_RSVD_A       3'h3
`define MODE_RESET        3'h4
`define MODE_RSVD_B       3'h5
`define MODE_PARTIAL_PD   3'h6
`define MODE_FULL_PD      3'h7
`define CTRL_START_BIT    7
`define CTRL_MODE_HI      6
`define CTRL_MODE_LO      4
`define CTRL_TAIL         4'h8
`define RANGE_BIPOLAR_FULL 3'h7
`define RANGE_UNI_POS_FULL 3'h3
`define CODE_ZERO_POS     14'h0000
`define CODE_ZERO_NEG     14'h3fff
`define PWR_NORMAL        2'h0
`define PWR_PARTIAL       2'h1
`define PWR_FULL          2'h2
`define REF_SETTLE_MS     10
`define CLOCK_MHZ         125
`endif

/* File: range_table.v */
// Per-channel input range storage with registered read port
`timescale 1ns/1ns
`default_nettype none
`include "adc_mode_map.vh"
module range_table #(
   parameter CHANNELS = 8,
   parameter AW       = 3
) (
   input  wire          clock,      // System clock
   input  wire          reset_n,    // Synchronous reset, active low
   input  wire          defaults,   // Restore every entry to default
   input  wire          wr_en,      // Write one entry
   input  wire [AW-1:0] wr_addr,    // Entry written
   input  wire [2:0]    wr_data,    // Range code written
   input  wire [AW-1:0] rd_addr,    // Entry read
   output reg  [2:0]    rd_data     // Registered range code
);
   reg [2:0] mem_q [0:CHANNELS-1];
   genvar g;
   // One entry per channel, independently writable
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : g_ent
         always @(posedge clock) begin
            if (!reset_n || defaults)
               mem_q[g] <= `RANGE_BIPOLAR_FULL;
            else if (wr_en && wr_addr == g)
               mem_q[g] <= wr_data;
         end
      end
   endgenerate
   // Registered read
   always @(posedge clock) begin
      if (!reset_n)
         rd_data <= `RANGE_BIPOLAR_FULL;
      else
         rd_data <= mem_q[rd_addr];
   end
endmodule // range_table
`default_nettype wire

/* File: host_serial_model.sv */
// Host side serial master that clocks mode bytes in
`timescale 1ns/1ns
`default_nettype none
module host_serial_model #(
   parameter int REF_WAIT_NS = 2000 // Reference settle wait, shortened for the bench
) (
   output logic sclk, // Serial clock, idles low
   output logic cs_n, // Chip select, active low
   output logic din   // Serial data
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b0;
   end
   // Frame of n bits, start bit first, 80 ns per bit
   // Host holds off conversions while the reference settles
   task automatic ref_settle;
      #(REF_WAIT_NS);
   endtask
   task automatic send(input logic [7:0] b, input int n);
      cs_n = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         din = b[i];
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      din = ~din; // Released line shows no stale bit
   endtask
endmodule // host_serial_model
`default_nettype wire

/* File: adc_power_mode_control_monitor.sv */
// Checker of mode, power and code outputs
`timescale 1ns/1ns
`default_nettype none
module adc_power_mode_control_monitor (
   input wire logic        clock,        // Clock
   input wire logic        reset_n,      // Reset, active low
   input wire logic [13:0] conv_raw,     // Raw code
   input wire logic [2:0]  mode_q,       // Mode
   input wire logic        analog_on_q,  // Analog power
   input wire logic        ref_on_q,     // Reference power
   input wire logic        mode_byte_q,  // Byte pulse
   input wire logic [2:0]  chan_range_q, // Range
   input wire logic [13:0] result_q      // Result
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   power_hold_a: assert property (!$past(mode_byte_q) |-> $stable({analog_on_q, ref_on_q}))
      else $error("power moved without byte");
   mode_hold_a: assert property (!mode_byte_q |-> $stable(mode_q))
      else $error("mode moved without byte");
   ref_gate_a: assert property (!ref_on_q |-> !analog_on_q)
      else $error("analog on without reference");
   mode_legal_a: assert property (mode_byte_q |-> mode_q <= 3'h2)
      else $error("illegal mode");
   pulse_once_a: assert property (mode_byte_q |=> !mode_byte_q [*8])
      else $error("byte pulse repeated");
   pos_code_a: assert property ($past(reset_n) && $stable(chan_range_q) &&
      chan_range_q != 3'h2 && chan_range_q != 3'h4 |-> result_q == $past(conv_raw))
      else $error("pass code wrong");
   neg_code_a: assert property ($past(reset_n) && $stable(chan_range_q) &&
      chan_range_q inside {3'h2, 3'h4} |-> result_q == 14'h3fff - $past(conv_raw))
      else $error("negative code wrong");
   reset_dflt_a: assert property (disable iff (1'b0) !reset_n |=> mode_q == 3'h0
      && analog_on_q && ref_on_q && !mode_byte_q && chan_range_q == 3'h7)
      else $error("reset state wrong");
   full_pd_c: cover property (!ref_on_q);
   part_pd_c: cover property (ref_on_q && !analog_on_q);
   neg_rng_c: cover property (chan_range_q == 3'h2);
endmodule // adc_power_mode_control_monitor
bind adc_power_mode_control adc_power_mode_control_monitor monitor_inst (.clock(clock),
   .reset_n(reset_n), .conv_raw(conv_raw), .mode_q(mode_q), .analog_on_q(analog_on_q),
   .ref_on_q(ref_on_q), .mode_byte_q(mode_byte_q), .chan_range_q(chan_range_q),
   .result_q(result_q));
`default_nettype wire

/* File: adc_power_mode_control_test.sv */
// Testbench of the mode and power control block
`timescale 1ns/1ns
`default_nettype none
`include "adc_mode_map.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module adc_power_mode_control_test;
   logic        clock, reset_n, range_wr;
   logic [2:0]  range_chan, range_code, conv_chan;
   logic [13:0] conv_raw;
   wire         sclk, cs_n, din, analog_on_q, ref_on_q, mode_byte_q;
   wire  [2:0]  mode_q, chan_range_q;
   wire  [13:0] result_q;
   int          err_total, comparisons, cyc, pulses;
   // Count valid-byte pulses seen on the output
   always @(posedge clock) begin
      if (mode_byte_q === 1'b1) pulses++;
   end
   host_serial_model host_serial_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din));
   adc_power_mode_control adc_power_mode_control_inst (.clock(clock), .reset_n(reset_n),
      .sclk(sclk), .cs_n(cs_n), .din(din), .range_wr(range_wr), .range_chan(range_chan),
      .range_code(range_code), .conv_chan(conv_chan), .conv_raw(conv_raw), .mode_q(mode_q),
      .analog_on_q(analog_on_q), .ref_on_q(ref_on_q), .mode_byte_q(mode_byte_q),
      .chan_range_q(chan_range_q), .result_q(result_q));
   // Send one mode byte, cut to n bits if asked, then settle
   task automatic mb(input logic [2:0] m, input int n = 8);
      host_serial_model_inst.send({1'b1, m, `CTRL_TAIL}, n);
      repeat (10) @(posedge clock);
      #1;
   endtask
   task automatic pw(input logic [2:0] m, input logic a, input logic r);
      `CHK("mode_q", m, mode_q)
      `CHK("analog_on_q", a, analog_on_q)
      `CHK("ref_on_q", r, ref_on_q)
   endtask
   task automatic wr(input logic [2:0] ch, input logic [2:0] code);
      @(posedge clock);
      #1 range_wr = 1'b1;
      range_chan = ch;
      range_code = code;
      @(posedge clock);
      #1 range_wr = 1'b0;
   endtask
   // Look up one channel and compare range and result
   task automatic look(input logic [2:0] ch, input logic [13:0] raw, input logic [2:0] rg,
      input logic [13:0] res);
      @(posedge clock);
      #1 conv_chan = ch;
      conv_raw = raw;
      repeat (3) @(posedge clock);
      #1 `CHK("chan_range_q", rg, chan_range_q)
      `CHK("result_q", res, result_q)
   endtask
   task automatic t_power_up;
      pw(`MODE_EXT_CLOCK, 1'b1, 1'b1);
      for (int c = 0; c < 8; c++) look(3'(c), 14'h0005, `RANGE_BIPOLAR_FULL, 14'h0005);
   endtask
   task automatic t_modes;
      for (int m = 0; m < 3; m++) begin
         mb(3'(m));
         pw(3'(m), 1'b1, 1'b1);
      end
   endtask
   // Power-down entry, glitches, reserved codes, then exits
   task automatic t_full_pd;
      int p;
      mb(`MODE_FULL_PD);
      pw(`MODE_INT_CLOCK, 1'b0, 1'b0);
      p = pulses;
      mb(`MODE_EXT_CLOCK, 5);
      host_serial_model_inst.send(8'h89, 8);
      repeat (10) @(posedge clock);
      mb(`MODE_RSVD_A);
      mb(`MODE_RSVD_B);
      pw(`MODE_INT_CLOCK, 1'b0, 1'b0);
      `CHK("mode_byte_q pulses", p + 2, pulses)
      mb(`MODE_PARTIAL_PD);
      pw(`MODE_INT_CLOCK, 1'b0, 1'b1);
      mb(`MODE_EXT_ACQ);
      pw(`MODE_EXT_ACQ, 1'b1, 1'b1);
      host_serial_model_inst.ref_settle;
   endtask
   task automatic t_ranges;
      wr(3'h1, `RANGE_UNI_POS_FULL);
      wr(3'h2, 3'h2);
      look(3'h1, 14'h0001, `RANGE_UNI_POS_FULL, `CODE_ZERO_POS + 14'h1);
      look(3'h2, 14'h0000, 3'h2, `CODE_ZERO_NEG);
      wr(3'h1, 3'h2);
      look(3'h1, 14'h0001, 3'h2, `CODE_ZERO_NEG - 14'h1);
      mb(`MODE_RESET);
      pw(`MODE_EXT_CLOCK, 1'b1, 1'b1);
      look(3'h1, 14'h0001, `RANGE_BIPOLAR_FULL, 14'h0001);
   endtask
   task automatic final_report;
      $display("err_total %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Cut a hang short
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         final_report;
      end
   end
   initial begin
      reset_n = 1'b0;
      range_wr = 1'b0;
      range_chan = 3'h0;
      range_code = 3'h0;
      conv_chan = 3'h0;
      conv_raw = 14'h0000;
      repeat (8) @(posedge clock);
      #1 reset_n = 1'b1;
      host_serial_model_inst.ref_settle;
      @(posedge clock);
      #1;
      t_power_up;
      t_modes;
      t_full_pd;
      t_ranges;
      final_report;
   end
endmodule // adc_power_mode_control_test
`default_nettype wire
